//--- logic/nvsc_host.sv
// host controller driving the nonvolatile sram through its pins
// What this block does
// - address steady across whole write
// - start store by lowering strobe last
// - hold recall condition at least 20 ns
// - no access until power-up recall elapsed
// - chip_on_n high means standby
module nvsc_host
	import nvsc_pkg::*;
#(
	parameter int STORE_CYCLES   = STORE_CYC,
	parameter int RESTORE_CYCLES = RESTORE_CYC
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// supply good above the store threshold, from a pin
	input  wire logic              power_good,
	// user command port
	input  wire logic              cmd_valid,
	input  nvsc_cmd_t              cmd_op,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_wdata,
	output logic                   cmd_ready,
	output logic [DATA_W-1:0]      rsp_rdata,
	output logic                   rsp_valid,
	// memory pins
	output logic [ADDR_W-1:0]      mem_addr,
	output nvsc_ctl_t              mem_ctl,
	input  wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe
);
	nvsc_regs_t          r_reg;
	nvsc_regs_t          r_next;
	logic [1:0]          pg_sync_reg;
	logic [DATA_W-1:0]   dq_s1_reg;
	logic [DATA_W-1:0]   dq_s2_reg;

	// wait length of each operation once its pulse ends
	function automatic logic [CNT_W-1:0] op_wait(input nvsc_cmd_t c);
		unique case (c)
			NVSC_CMD_STORE:  op_wait = CNT_W'(STORE_CYCLES);
			NVSC_CMD_RECALL: op_wait = CNT_W'(RECALL_CYC);
			// read waits two extra edges for the dq synchroniser
			NVSC_CMD_READ:   op_wait = CNT_W'(ACCESS_CYC + 2);
			default:         op_wait = CNT_W'(1);
		endcase
	endfunction

	// pin inputs pass two flops; the first is read by nothing else
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pg_sync_reg <= 2'h0;
			dq_s1_reg   <= 8'h00;
			dq_s2_reg   <= 8'h00;
		end else begin
			pg_sync_reg <= {pg_sync_reg[0], power_good};
			dq_s1_reg   <= dq_in;
			dq_s2_reg   <= dq_s1_reg;
		end
	end

	// next-state logic for the whole controller
	always_comb begin
		r_next        = r_reg;
		r_next.rvalid = 1'b0;
		unique case (r_reg.st)
			// hold off until power-up recall has elapsed
			NVSC_BOOT: begin
				r_next.ctl = CTL_IDLE;
				if (!pg_sync_reg[1]) begin
					r_next.cnt = CNT_W'(RESTORE_CYCLES);
				end else if (r_reg.cnt == '0) begin
					r_next.st = NVSC_IDLE;
				end else begin
					r_next.cnt = r_reg.cnt - CNT_W'(1);
				end
			end
			NVSC_IDLE: begin
				r_next.ctl   = CTL_IDLE;
				r_next.dq_oe = 1'b0;
				if (!pg_sync_reg[1]) begin
					r_next.st  = NVSC_BOOT;
					r_next.cnt = CNT_W'(RESTORE_CYCLES);
				end else if (cmd_valid) begin
					r_next.cmd   = cmd_op;
					r_next.addr  = cmd_addr;
					r_next.wdata = cmd_wdata;
					r_next.st    = NVSC_SETUP;
				end
			end
			// set mode pins and address before the last edge; a write lowers its strobe here already
			NVSC_SETUP: begin
				r_next.st  = NVSC_PULSE;
				r_next.cnt = CNT_W'(INIT_CYC);
				unique case (r_reg.cmd)
					// chip and output drive low, strobe and nonvol high
					NVSC_CMD_READ:   r_next.ctl = 4'h3;
					// output drive stays high through writes
					NVSC_CMD_WRITE: begin
						r_next.ctl   = 4'h5;
						r_next.dq_oe = 1'b1;
					end
					// chip and nonvol low, strobe still high
					NVSC_CMD_STORE:  r_next.ctl = 4'h6;
					// strobe kept high so recall is not a store
					NVSC_CMD_RECALL: r_next.ctl = 4'h6;
					default:         r_next.ctl = CTL_IDLE;
				endcase
			end
			NVSC_PULSE: begin
				// address and data stay put through the strobe
				if (r_reg.cmd == NVSC_CMD_WRITE) begin
					r_next.ctl.put_strobe_n = 1'b0;
				end
				// a store is dropped when supply sags
				if (r_reg.cmd == NVSC_CMD_STORE && pg_sync_reg[1]) begin
					r_next.ctl.put_strobe_n = 1'b0;
				end
				// recall starts on output drive falling last
				if (r_reg.cmd == NVSC_CMD_RECALL) begin
					r_next.ctl.output_drive_n = 1'b0;
				end
				if (r_reg.cmd == NVSC_CMD_READ) begin
					r_next.st  = NVSC_WAIT;
					r_next.cnt = op_wait(r_reg.cmd);
				end else if (r_reg.cnt == '0) begin
					// pulse held at least the initiation time
					r_next.ctl   = CTL_IDLE;
					r_next.dq_oe = 1'b0;
					r_next.st    = NVSC_WAIT;
					r_next.cnt   = op_wait(r_reg.cmd);
				end else begin
					r_next.cnt = r_reg.cnt - CNT_W'(1);
				end
			end
			// wait out each operation; the bus is released for all but a read, which keeps its pins
			NVSC_WAIT: begin
				if (r_reg.cnt == '0) begin
					r_next.st = NVSC_FINISH;
				end else begin
					r_next.cnt = r_reg.cnt - CNT_W'(1);
				end
			end
			NVSC_FINISH: begin
				// sample read data after access time
				if (r_reg.cmd == NVSC_CMD_READ) begin
					r_next.rdata  = dq_s2_reg;
				end
				r_next.rvalid = 1'b1;
				r_next.ctl    = CTL_IDLE;
				r_next.st     = NVSC_IDLE;
			end
			default: begin
				r_next.st  = NVSC_IDLE;
				r_next.ctl = CTL_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r_reg       <= '0;
			r_reg.st    <= NVSC_BOOT;
			r_reg.ctl   <= CTL_IDLE;
			r_reg.cmd   <= NVSC_CMD_READ;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from flops, except cmd_ready, which ands the idle state with synced power good
	assign mem_addr  = r_reg.addr;
	assign mem_ctl   = r_reg.ctl;
	assign dq_out    = r_reg.wdata;
	assign dq_oe     = r_reg.dq_oe;
	assign rsp_rdata = r_reg.rdata;
	assign rsp_valid = r_reg.rvalid;
	assign cmd_ready = (r_reg.st == NVSC_IDLE) && pg_sync_reg[1];

	// store pulse shape: erase and program run inside the device
	sequence s_store_arm;
		r_reg.st == NVSC_SETUP && r_reg.cmd == NVSC_CMD_STORE;
	endsequence

	// chip and nonvol low first, strobe still high
	sequence s_store_ready;
		mem_ctl == 4'h6;
	endsequence

	// store pins reached with strobe last
	chk_store_strobe_last: assert property (@(posedge mclk) disable iff (!resetn)
		s_store_arm |=> s_store_ready ##1 (mem_ctl == 4'h4 ||
		!$past(pg_sync_reg[1]))) else $error("store arm wrong");
	// never drive dq with output drive low
	chk_no_contention: assert property (@(posedge mclk) disable iff (!resetn)
		dq_oe |-> mem_ctl.output_drive_n) else $error("bus contention");
	chk_idle_standby: assert property (@(posedge mclk) disable iff (!resetn)
		r_reg.st == NVSC_IDLE |-> mem_ctl.chip_on_n) else $error("not standby");
	chk_recall_nostrobe: assert property (@(posedge mclk) disable iff (!resetn)
		r_reg.cmd == NVSC_CMD_RECALL && r_reg.st != NVSC_IDLE
		|-> mem_ctl.put_strobe_n) else $error("recall with strobe");
	// recall condition stands until the count runs out
	chk_recall_hold: assert property (@(posedge mclk) disable iff (!resetn)
		r_reg.st == NVSC_PULSE && r_reg.cmd == NVSC_CMD_RECALL &&
		r_reg.cnt != '0 |=> !mem_ctl.output_drive_n)
		else $error("recall too short");
	// no store edge without power good
	chk_store_inhibit: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(mem_ctl.put_strobe_n) && !mem_ctl.nonvol_mode_n
		|-> $past(pg_sync_reg[1])) else $error("store at low supply");
	chk_addr_stable: assert property (@(posedge mclk) disable iff (!resetn)
		!mem_ctl.put_strobe_n && !$past(mem_ctl.put_strobe_n)
		|-> $stable(mem_addr)) else $error("address moved");
	chk_boot_block: assert property (@(posedge mclk) disable iff (!resetn)
		r_reg.st == NVSC_BOOT |-> !cmd_ready) else $error("early access");
endmodule

//--- logic/nvsc_pkg.sv
// package for the nonvolatile sram host controller
package nvsc_pkg;
	localparam int CLK_MHZ        = 25;
	localparam int ADDR_W         = 11;
	localparam int DATA_W         = 8;
	// timing figures in their own units
	localparam int T_STORE_MS     = 10;
	localparam int T_RECALL_US    = 20;
	localparam int T_RESTORE_US   = 550;
	localparam int T_INIT_NS      = 20;
	localparam int T_ACCESS_NS    = 45;
	// cycle counts derived at 25 MHz
	localparam int STORE_CYC      = T_STORE_MS * 1000 * CLK_MHZ;
	localparam int RECALL_CYC     = T_RECALL_US * CLK_MHZ;
	localparam int RESTORE_CYC    = T_RESTORE_US * CLK_MHZ;
	localparam int INIT_CYC       = (T_INIT_NS * CLK_MHZ + 999) / 1000;
	localparam int ACCESS_CYC     = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W          = 20;

	// host commands
	typedef enum logic [2:0] {
		NVSC_CMD_READ   = 3'h0,
		NVSC_CMD_WRITE  = 3'h1,
		NVSC_CMD_STORE  = 3'h2,
		NVSC_CMD_RECALL = 3'h3
	} nvsc_cmd_t;

	// one-hot controller states
	typedef enum logic [5:0] {
		NVSC_BOOT   = 6'h01,
		NVSC_IDLE   = 6'h02,
		NVSC_SETUP  = 6'h04,
		NVSC_PULSE  = 6'h08,
		NVSC_WAIT   = 6'h10,
		NVSC_FINISH = 6'h20
	} nvsc_state_t;

	// control pins toward the memory, all active low
	typedef struct packed {
		logic chip_on_n;
		logic output_drive_n;
		logic put_strobe_n;
		logic nonvol_mode_n;
	} nvsc_ctl_t;

	localparam nvsc_ctl_t CTL_IDLE = 4'hf;

	// whole controller state
	typedef struct packed {
		nvsc_state_t         st;
		nvsc_cmd_t           cmd;
		nvsc_ctl_t           ctl;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic                dq_oe;
		logic [DATA_W-1:0]   rdata;
		logic                rvalid;
		logic [CNT_W-1:0]    cnt;
	} nvsc_regs_t;
endpackage

//--- testbench/nvsc_mem_model.sv
// behavioural model of the nonvolatile sram behind the host
module nvsc_mem_model
	import nvsc_pkg::*;
#(
	parameter int T_ST = 200,
	parameter int T_RC = 1000,
	parameter int T_RS = 200
) (
	// pins driven by the host
	input  wire logic [ADDR_W-1:0] addr,
	input  nvsc_ctl_t              ctl,
	input  wire logic [DATA_W-1:0] din,
	input  wire logic              din_oe,
	// supply above the trigger level
	input  wire logic              vcc_ok,
	// data back to the host, count of host slips
	output logic [DATA_W-1:0]      q,
	output int                     errs = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	// durations are parameters, vcc_ok is the supply
	logic [DATA_W-1:0] sram [2**ADDR_W] = '{default: 8'h00};
	logic [DATA_W-1:0] nv   [2**ADDR_W] = '{default: 8'h00};
	logic [DATA_W-1:0] pd   = 8'h00;
	logic [ADDR_W-1:0] pa   = 11'h000;
	logic [3:0]        pk   = 4'hf;
	logic              busy = 1'h0;
	logic              poe, pr, ps, pw;
	realtime           t_rc = 0;
	// pin decode {chip, output, strobe, nonvol}, chip high is standby
	wire logic [3:0]   k  = ctl;
	wire logic         rd = k == 4'h3;
	wire logic         wr = !k[3] && !k[1] && k[0];
	wire logic         st = k == 4'h4;
	wire logic         rc = k == 4'h2;
	// reads follow the address; a busy or idle bus shows a wrong pattern
	assign q = (rd && !busy) ? sram[addr] : ~sram[addr];
	// evaluate 1 ns after each host edge so pins change together
	always begin
		@(ctl or addr);
		#1;
		if (wr && pw && addr != pa)
			errs++;
		if (!rc && pr && $realtime - t_rc < 20)
			errs++;
		if (rc && !pr)
			t_rc = $realtime;
		// a store attempt at low supply is a host slip
		if (st && !ps && !vcc_ok)
			errs++;
		if (!busy) begin
			if (pw && !wr)
				sram[pa] = poe ? pd : ~pd;
			if (st && !ps && vcc_ok) begin
				if (pk[0] || !pk[2])
					errs++;
				busy = 1'h1;
				fork begin
					#(T_ST);
					nv = sram;
					busy = 1'h0;
				end join_none
			end
			if (rc && !pr) begin
				busy = 1'h1;
				fork begin
					#(T_RC);
					sram = '{default: 8'h00};
					sram = nv;
					busy = 1'h0;
				end join_none
			end
		end
		{pr, ps, pw, poe, pd, pa, pk} = {rc, st, wr, din_oe, din, addr, k};
	end
	always @(posedge vcc_ok) begin
		busy = 1'h1;
		#(T_RS);
		sram = nv;
		if (wr)
			sram[addr] = ~sram[addr];
		busy = 1'h0;
	end
endmodule

//--- testbench/tb.sv
// self-checking bench for the nonvolatile sram host controller
module tb
	import nvsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		nvsc_cmd_t         op;
		logic [ADDR_W-1:0] ad;
		logic [DATA_W-1:0] wd;
		logic [DATA_W-1:0] ex;
	} nvsc_row_t;
	logic              mclk = 1'h0;
	logic              resetn = 1'h0;
	logic              power_good = 1'h0;
	logic              cmd_valid = 1'h0;
	nvsc_cmd_t         cmd_op = NVSC_CMD_READ;
	logic [ADDR_W-1:0] cmd_addr = 11'h000;
	logic [DATA_W-1:0] cmd_wdata = 8'h00;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] rsp_rdata, dq_in, dq_out;
	logic              cmd_ready, rsp_valid, dq_oe;
	nvsc_ctl_t         mem_ctl;
	int                miscompares = 0, checks = 0, errs, n;
	// op, address, write data, expected read data
	nvsc_row_t rows [10] = '{
		'{NVSC_CMD_WRITE,  11'h000, 8'h5a, 8'h00},
		'{NVSC_CMD_WRITE,  11'h7ff, 8'ha5, 8'h00},
		'{NVSC_CMD_READ,   11'h000, 8'h00, 8'h5a},
		'{NVSC_CMD_READ,   11'h7ff, 8'h00, 8'ha5},
		'{NVSC_CMD_STORE,  11'h000, 8'h00, 8'h00},
		'{NVSC_CMD_WRITE,  11'h000, 8'h3c, 8'h00},
		'{NVSC_CMD_READ,   11'h000, 8'h00, 8'h3c},
		'{NVSC_CMD_RECALL, 11'h000, 8'h00, 8'h00},
		'{NVSC_CMD_READ,   11'h000, 8'h00, 8'h5a},
		'{NVSC_CMD_READ,   11'h7ff, 8'h00, 8'ha5}
	};
	// short store and boot counts keep the run brief
	nvsc_host #(.STORE_CYCLES(20), .RESTORE_CYCLES(10)) nvsc_host_i (
		.mclk, .resetn, .power_good, .cmd_valid, .cmd_op, .cmd_addr,
		.cmd_wdata, .cmd_ready, .rsp_rdata, .rsp_valid, .mem_addr,
		.mem_ctl, .dq_in, .dq_out, .dq_oe);
	nvsc_mem_model nvsc_mem_model_i (.addr(mem_addr), .ctl(mem_ctl),
		.din(dq_out), .din_oe(dq_oe), .vcc_ok(power_good), .q(dq_in),
		.errs(errs));
	always #20 mclk = ~mclk;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one command; drop cuts the supply as the command is offered
	task automatic do_op(input nvsc_cmd_t op, input logic [10:0] ad,
		input logic [7:0] wd, input logic drop);
		@(negedge mclk);
		n = 0;
		while (cmd_ready !== 1'h1 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		cmd_op = op;
		cmd_addr = ad;
		cmd_wdata = wd;
		cmd_valid = 1'h1;
		power_good = !drop;
		@(negedge mclk);
		cmd_valid = 1'h0;
		n = 0;
		while (rsp_valid !== 1'h1 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		check(n < 2000, 1'h1);
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		check(mem_ctl, CTL_IDLE);
		check(dq_oe, 1'h0);
		resetn = 1'h1;
		repeat (4) @(negedge mclk);
		check(cmd_ready, 1'h0);
		power_good = 1'h1;
		n = 0;
		while (cmd_ready !== 1'h1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		check(n >= 10 && n < 100, 1'h1);
		$display("boot test done");
		foreach (rows[i]) begin
			do_op(rows[i].op, rows[i].ad, rows[i].wd, 1'h0);
			if (rows[i].op == NVSC_CMD_READ)
				check(rsp_rdata, rows[i].ex);
		end
		$display("row tests done");
		// a store offered as the supply falls must not take
		do_op(NVSC_CMD_WRITE, 11'h000, 8'h11, 1'h0);
		do_op(NVSC_CMD_STORE, 11'h000, 8'h00, 1'h1);
		power_good = 1'h1;
		do_op(NVSC_CMD_READ, 11'h000, 8'h00, 1'h0);
		check(rsp_rdata, 8'h5a);
		check(errs, 16'h0000);
		$display("power test done");
		summarize();
	end
	// whole run is near 28 us, 20 us of it the recall wait
	initial begin
		#200us;
		miscompares++;
		summarize();
	end
endmodule
